// ==== logic/epc_pkg.sv ====
// Purpose: constants for the eprom program control block
// Assumes: 8-bit cpu register space mapped onto an avalon word bus
// Notes: offsets are byte addresses on the avalon side
package epc_pkg;
  localparam logic [15:0] EPC_CTRL_IDX = 16'h0007;
  localparam logic [15:0] EPC_OPT_IDX = 16'h1efe;
  localparam logic [15:0] EPC_STAT_IDX = 16'h0010;
  localparam logic [15:0] EPC_MODE_IDX = 16'h0011;
  localparam int EPC_AW = 13;
  localparam logic [12:0] EPC_VEC_LO = 13'h1ff2;
  localparam logic [12:0] EPC_SEC_LO = 13'h0000;
  localparam logic [12:0] EPC_SEC_HI = 13'h00ff;
  localparam logic [7:0] EPC_ERASED = 8'h00;
  localparam int EPC_B_PPT = 6;
  localparam int EPC_B_LAT = 5;
  localparam int EPC_B_PGM = 4;
  localparam int EPC_B_EXTERNAL_CLOCK_OPTION_BIT = 3;
  localparam int EPC_B_EPP = 7;
  localparam logic [7:0] EPC_OPT_WMASK = 8'hbf;
  localparam logic [7:0] EPC_OPT_RESET = 8'h00;
  typedef enum logic [1:0] {
    EPC_IDLE = 2'b00,
    EPC_LATCH = 2'b01,
    EPC_PROG = 2'b10
  } epc_state_e;
endpackage

// ==== logic/epc_array.sv ====
// Purpose: one-time-programmable cell array model, bits only ever set
// Assumes: program strobe carries up to four bytes in one aligned group
// Notes: array starts erased to zero
`timescale 1ns/1ps
module epc_array import epc_pkg::*; #(
  parameter int AW = EPC_AW
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // read port
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  // program port
  input wire logic prog_en,
  input wire logic [AW-3:0] prog_group,
  input wire logic [3:0] prog_mask,
  input wire logic [31:0] prog_data
);
  logic [7:0] cells [0:(1<<AW)-1] = '{default: EPC_ERASED}; // blank cells at power-up
  // program cells: or-in new ones, never clear
  always_ff @(posedge clk_sys) begin
    if (prog_en) begin
      for (int i = 0; i < 4; i++) begin
        if (prog_mask[i]) begin
          cells[{prog_group, 2'(i)}] <= cells[{prog_group, 2'(i)}] | prog_data[8*i +: 8];
        end
      end
    end
  end
  // registered read
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= cells[rd_addr];
    end
  end
endmodule

// ==== logic/epc_sync.sv ====
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: single-bit level inputs
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module epc_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // level in and out
  input wire logic din,
  output logic dout
);
  logic meta_q;
  // two stage capture
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// ==== logic/epc_top.sv ====
// Purpose: eprom programming control with avalon register access
// Assumes: cpu reaches control, options and array over one avalon slave
// Notes: array word space starts at byte 0x8000 (index times four)
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module epc_top import epc_pkg::*; #(
  parameter int AW = EPC_AW
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // system events and pins
  input wire logic stop_req,
  input wire logic bootloader_mode,
  // programming status out
  output logic supply_request,
  output logic vector_zone_hit,
  output logic program_active
);
  logic [7:0] opt_q = EPC_OPT_RESET; // blank cells at power-up
  logic ppt_q, lat_q, pgm_q, external_clock_option_bit_q, ppt_d;
  logic any_byte_q;
  logic [AW-3:0] grp_q;
  logic [3:0] mask_q;
  logic [31:0] data_q;
  logic rst_seen_q;
  logic boot_s;
  logic [7:0] arr_rd;
  logic ack_q, rd_pend_q, done;
  logic arr_sel, req, wr_ok, ctrl_wr, pgm_d;
  logic [AW-1:0] arr_addr;
  logic [1:0] lane;
  logic [7:0] wbyte;
  logic prog_go;
  epc_state_e st_q;

  // pick the enabled byte lane and its data
  function automatic logic [1:0] lane_of(input logic [3:0] be);
    lane_of = be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : 2'd3;
  endfunction

  // bootloader strap synchronised
  epc_sync u_boot (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .din(bootloader_mode),
    .dout(boot_s)
  );

  // address decode; array window in upper half of index space
  assign arr_sel = avs_address[15];
  assign arr_addr = avs_address[AW+1:2];
  assign lane = lane_of(avs_byteenable);
  assign wbyte = avs_writedata[8*lane +: 8];
  assign req = (avs_read | avs_write) & ~ack_q;
  // array reads wait one more cycle for the registered cell read
  assign done = req & ~(avs_read & arr_sel & ~rd_pend_q);
  // writes land at the edge where waitrequest is seen low
  assign wr_ok = avs_write & ~avs_waitrequest;
  assign ctrl_wr = wr_ok && avs_address == EPC_CTRL_IDX;
  assign ppt_d = opt_q[EPC_B_EPP];

  // one wait state, two for array reads, then release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= done;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~done;
    end
  end

  // options register: nonvolatile cells, untouched by any reset
  always_ff @(posedge clk_sys) begin
    if (wr_ok && avs_address == EPC_OPT_IDX && boot_s) begin
      opt_q <= avs_writedata[7:0] & EPC_OPT_WMASK;
    end
  end

  // protect copy reloaded once after each reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ppt_q <= 1'b0;
    end else if (!rst_seen_q) begin
      ppt_q <= ppt_d;
    end
  end

  // external clock option bit, plain storage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      external_clock_option_bit_q <= 1'b0;
    end else if (ctrl_wr) begin
      external_clock_option_bit_q <= avs_writedata[EPC_B_EXTERNAL_CLOCK_OPTION_BIT];
    end
  end

  // latch enable: cleared by stop and reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lat_q <= 1'b0;
    end else if (stop_req) begin
      lat_q <= 1'b0;
    end else if (ctrl_wr) begin
      lat_q <= avs_writedata[EPC_B_LAT];
    end
  end

  // program enable: set only after a latched byte, cleared only with latch
  always_comb begin
    pgm_d = pgm_q;
    if (stop_req || !lat_q || (ctrl_wr && !avs_writedata[EPC_B_LAT])) begin
      pgm_d = 1'b0;
    end else if (ctrl_wr && avs_writedata[EPC_B_PGM] && avs_writedata[EPC_B_LAT] && any_byte_q) begin
      pgm_d = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pgm_q <= 1'b0;
    end else begin
      pgm_q <= pgm_d;
    end
  end

  // latch address group and up to four bytes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      any_byte_q <= 1'b0;
      grp_q <= '0;
      mask_q <= 4'h0;
      data_q <= 32'h0;
    end else if (!lat_q) begin
      any_byte_q <= 1'b0;
      mask_q <= 4'h0;
    end else if (wr_ok && arr_sel && !pgm_q) begin
      if (!any_byte_q || arr_addr[AW-1:2] != grp_q) begin
        grp_q <= arr_addr[AW-1:2];
        mask_q <= 4'h1 << arr_addr[1:0];
      end else begin
        mask_q <= mask_q | (4'h1 << arr_addr[1:0]);
      end
      data_q[8*arr_addr[1:0] +: 8] <= wbyte;
      any_byte_q <= 1'b1;
    end
  end

  // state of the programming sequence
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= EPC_IDLE;
    end else begin
      case (st_q)
        EPC_IDLE: begin
          if (lat_q) begin
            st_q <= EPC_LATCH;
          end
        end
        EPC_LATCH: begin
          if (!lat_q) begin
            st_q <= EPC_IDLE;
          end else if (pgm_q) begin
            st_q <= EPC_PROG;
          end
        end
        EPC_PROG: begin
          if (!pgm_q) begin
            st_q <= EPC_IDLE;
          end
        end
        default: begin
          st_q <= EPC_IDLE;
        end
      endcase
    end
  end

  // protect gates only the main array
  assign prog_go = (st_q == EPC_PROG) && pgm_q
                   && (!ppt_q || grp_q <= EPC_SEC_HI[AW-1:2]);

  epc_array #(.AW(AW)) u_arr (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .rd_addr(arr_addr),
    .rd_data(arr_rd),
    .prog_en(prog_go),
    .prog_group(grp_q),
    .prog_mask(mask_q),
    .prog_data(data_q)
  );

  // array read pending while the cell read settles
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= req & avs_read & arr_sel & ~rd_pend_q;
    end
  end

  // read data mux
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_q && !arr_sel) begin
      avs_readdata <= 32'h0;
      if (avs_address == EPC_CTRL_IDX) begin
        // bit 7 always zero; protect copy visible even while latched
        avs_readdata[7:0] <= {1'b0, ppt_q, lat_q, pgm_q, external_clock_option_bit_q, 3'b000};
      end else if (avs_address == EPC_OPT_IDX) begin
        avs_readdata[7:0] <= opt_q;
      end else if (avs_address == EPC_STAT_IDX) begin
        avs_readdata[7:0] <= {4'h0, any_byte_q, boot_s, st_q};
      end
    end else if (rd_pend_q) begin
      // array hidden while latched
      avs_readdata <= lat_q ? 32'h0 : {24'h0, arr_rd};
    end
  end

  // supply request and status pins
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      supply_request <= 1'b0;
      vector_zone_hit <= 1'b0;
      program_active <= 1'b0;
    end else begin
      supply_request <= pgm_d;
      vector_zone_hit <= avs_read & arr_sel & (arr_addr >= EPC_VEC_LO);
      program_active <= prog_go;
    end
  end
endmodule

// ==== bench/epc_chk_sva.sv ====
// Purpose: port-level checks on the eprom program control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every epc_top instance
`timescale 1ns/1ps
module epc_chk import epc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // avalon slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // events and status
  input wire logic stop_req,
  input wire logic supply_request,
  input wire logic vector_zone_hit,
  input wire logic program_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  // accepted control write and array read in the vector zone
  wire logic ctrl_wr = avs_write && !avs_waitrequest && avs_address == EPC_CTRL_IDX;
  wire logic vec_rd = avs_read && avs_address[15] && avs_address[14:2] >= EPC_VEC_LO;
  // one wait state, two for array reads, then waitrequest back up
  property p_answer;
    (avs_write || (avs_read && !avs_address[15])) && avs_waitrequest |-> ##1 !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered in one cycle");
  property p_arr_answer;
    avs_read && avs_address[15] && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_arr_answer: assert property (p_arr_answer) else $error("array read not answered in two cycles");
  property p_one_low;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
  property p_bit7;
    avs_read && !avs_waitrequest && avs_address == EPC_CTRL_IDX |-> !avs_readdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("control bit 7 read as one");
  // program enable only from a write carrying latch and program
  property p_pgm_rise;
    $rose(supply_request) |-> $past(ctrl_wr && avs_writedata[5:4] == 2'b11);
  endproperty
  a_pgm_rise: assert property (p_pgm_rise) else $error("program enable set without cause");
  property p_pgm_fall;
    $fell(supply_request) |-> $past((ctrl_wr && !avs_writedata[5]) || stop_req);
  endproperty
  a_pgm_fall: assert property (p_pgm_fall) else $error("program enable cleared without cause");
  property p_stop;
    stop_req |=> !supply_request;
  endproperty
  a_stop: assert property (p_stop) else $error("stop left program enable set");
  property p_active;
    program_active |-> supply_request || $past(supply_request);
  endproperty
  a_active: assert property (p_active) else $error("array programmed without enable");
  property p_vec;
    vector_zone_hit |-> $past(vec_rd) || $past(vec_rd, 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector hit without vector read");
  // main scenarios reached
  c_prog: cover property ($rose(supply_request));
  c_vec: cover property (vector_zone_hit);
  c_stop: cover property (stop_req && supply_request);
endmodule
bind epc_top epc_chk epc_chk_i (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .stop_req(stop_req), .supply_request(supply_request),
  .vector_zone_hit(vector_zone_hit), .program_active(program_active));

// ==== bench/epc_supply_model.sv ====
// Purpose: external high-voltage switch driven by the supply request
// Assumes: rail settles a few cycles after the request
// Notes: drops the rail on the first clock edge after the request goes away
`timescale 1ns/1ps
module epc_supply_model #(
  parameter int SETTLE = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // switch control and rail
  input wire logic supply_request,
  output logic hv_on
);
  logic [3:0] cnt_q;
  // count request time, rail only follows an enable already set
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
    end else if (!supply_request) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'(SETTLE)) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  assign hv_on = cnt_q == 4'(SETTLE);
endmodule

// ==== bench/epc_tb_top.sv ====
// Purpose: self-checking bench for the eprom program control block
// Assumes: bench acts as cpu software over avalon
// Notes: array reads are issued twice, the second answer is used
`timescale 1ns/1ps
module epc_tb_top import epc_pkg::*;;
  logic clk_sys, arst_n, avs_read, avs_write, stop_req, bootloader_mode;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest, supply_request, vector_zone_hit, program_active, hv_on;
  int fails, checked;
  logic vz_seen = 1'b0;
  // remembers any vector zone pulse
  always @(posedge clk_sys) begin
    if (vector_zone_hit) begin
      vz_seen <= 1'b1;
    end
  end
  epc_top epc_top_i (.clk_sys(clk_sys), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_req(stop_req),
    .bootloader_mode(bootloader_mode), .supply_request(supply_request),
    .vector_zone_hit(vector_zone_hit), .program_active(program_active));
  epc_supply_model epc_supply_model_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .supply_request(supply_request), .hv_on(hv_on));
  // 50 mhz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task results;
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      n++;
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) fails++;
    @(posedge clk_sys);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hf);
  endtask
  task rd(input logic [15:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // byte on every lane, byteenable picks it
  task arr_wr(input logic [12:0] a, input logic [7:0] d);
    bus(1'b1, {1'b1, a, 2'b00}, {4{d}}, 4'h1 << a[1:0]);
  endtask
  task arr_rd(input logic [12:0] a);
    rd({1'b1, a, 2'b00});
    rd({1'b1, a, 2'b00});
  endtask
  // latch a group, program it, drop the latch
  task prog(input logic [12:0] a, input logic [31:0] d);
    wr(EPC_CTRL_IDX, 8'h20);
    for (int i = 0; i < 4; i++) arr_wr(a + 13'(i), d[8*i +: 8]);
    wr(EPC_CTRL_IDX, 8'h30);
    repeat (6) @(posedge clk_sys);
    wr(EPC_CTRL_IDX, 8'h00);
  endtask
  task do_reset(input int n);
    arst_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  // watchdog
  initial begin
    #200000;
    fails++;
    results;
  end
  // main sequence
  initial begin
    {avs_read, avs_write, stop_req, bootloader_mode} = 4'h0;
    avs_address = 16'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    do_reset(6);
    rd(EPC_CTRL_IDX); check("ctrl reset", q[7:0], 8'h00);
    arr_rd(13'h0400); check("blank byte", q[7:0], EPC_ERASED);
    wr(EPC_CTRL_IDX, 8'h10); rd(EPC_CTRL_IDX); check("pgm no latch", q[7:0], 8'h00);
    wr(EPC_CTRL_IDX, 8'h20); wr(EPC_CTRL_IDX, 8'h30);
    rd(EPC_CTRL_IDX); check("pgm no byte", q[7:0], 8'h20);
    for (int i = 0; i < 4; i++) arr_wr(13'h0400 + 13'(i), 8'ha5 + 8'(i * 17));
    wr(EPC_CTRL_IDX, 8'h30); rd(EPC_CTRL_IDX); check("pgm set", q[7:0], 8'h30);
    repeat (5) @(posedge clk_sys);
    check("supply", {hv_on, supply_request, program_active}, 3'b111);
    arr_wr(13'h0400, 8'h40);
    wr(EPC_CTRL_IDX, 8'h20); rd(EPC_CTRL_IDX); check("pgm held", q[7:0], 8'h30);
    wr(EPC_CTRL_IDX, 8'h00); rd(EPC_CTRL_IDX); check("latch drop", q[7:0], 8'h00);
    arr_rd(13'h0400); check("group byte", q[7:0], 8'ha5);
    prog(13'h0400, 32'h5a); arr_rd(13'h0400); check("bits set", q[7:0], 8'hff);
    check("vector idle", vz_seen, 1'b0);
    arr_rd(EPC_VEC_LO); check("vector zone", vz_seen, 1'b1);
    wr(EPC_OPT_IDX, 8'h80); rd(EPC_OPT_IDX); check("opt locked", q[7:0], 8'h00);
    bootloader_mode <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(EPC_OPT_IDX, 8'hff); rd(EPC_OPT_IDX); check("opt boot", q[7:0], EPC_OPT_WMASK);
    bootloader_mode <= 1'b0;
    rd(EPC_CTRL_IDX); check("copy waits", q[7:0], 8'h00);
    do_reset(2);
    rd(EPC_OPT_IDX); check("opt kept", q[7:0], EPC_OPT_WMASK);
    rd(EPC_CTRL_IDX); check("copy load", q[7:0], 8'h40);
    wr(EPC_CTRL_IDX, 8'h20); rd(EPC_CTRL_IDX); check("copy latched", q[7:0], 8'h60);
    arr_rd(13'h0400); check("array hidden", q[7:0], 8'h00);
    wr(EPC_CTRL_IDX, 8'h00);
    prog(13'h0800, 32'h77); arr_rd(13'h0800); check("main locked", q[7:0], 8'h00);
    prog(13'h0010, 32'h77); arr_rd(13'h0010); check("second open", q[7:0], 8'h77);
    arr_rd(13'h0400); check("main reads", q[7:0], 8'hff);
    wr(EPC_CTRL_IDX, 8'h20); arr_wr(13'h0404, 8'h01); wr(EPC_CTRL_IDX, 8'h30);
    stop_req <= 1'b1;
    @(posedge clk_sys);
    stop_req <= 1'b0;
    @(posedge clk_sys);
    rd(EPC_CTRL_IDX); check("stop clear", q[7:0], 8'h40);
    results;
  end
endmodule
